// file: pwm_pkg.sv
// Constants and types shared by the three-phase gate generator
package pwm_pkg;
	localparam int PH_W   = 24;
	localparam int ANG_W  = 16;
	localparam int CAR_W  = 12;
	localparam int DT_W   = 8;
	localparam int AMP_W  = 8;
	localparam int SPD_W  = 16;
	localparam int SIN_W  = 14;
	localparam int NPH    = 3;
	localparam int CLK_NS = 50;
	localparam int DEAD_NS  = 2000;
	localparam int DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
	localparam logic signed [SIN_W-1:0] FULL = 14'sh07ff;
	localparam logic [ANG_W-1:0] LAG [NPH] = '{16'h0000, 16'h5555,
		16'haaaa};
	localparam logic [10:0] SINE_Q [16] = '{11'h064, 11'h12c, 11'h1f1,
		11'h2b2, 11'h36b, 11'h41c, 11'h4c3, 11'h55f, 11'h5ed, 11'h66c,
		11'h6dc, 11'h73b, 11'h787, 11'h7c2, 11'h7e9, 11'h7fd};
	localparam logic [2:0] SECTORS    = 3'h6;
	localparam logic [2:0] SEC_H120_E = 3'h2;
	localparam logic [2:0] SEC_L120_B = 3'h3;
	localparam logic [2:0] SEC_L120_E = 3'h5;
	localparam logic [2:0] SEC_HALF   = 3'h3;
	typedef enum logic [2:0] {
		MODE_OFF,
		MODE_BLK120,
		MODE_BLK180,
		MODE_SINE3,
		MODE_DPWM_BOTH,
		MODE_DPWM_LOW
	} mode_type;
endpackage : pwm_pkg

// file: three_phase_commutation_pwm.sv
// Six-output gate generator for a three-phase bridge
`timescale 1ns/1ps
module three_phase_commutation_pwm
	import pwm_pkg::*;
#(
	parameter logic [pwm_pkg::DT_W-1:0] DEAD_CYCLES =
		pwm_pkg::DT_W'(pwm_pkg::DEAD_CYC)
) (
	input  wire                        core_clk,
	input  wire                        rst_n,
	input  pwm_pkg::mode_type          mode,
	input  wire                        low_side_pwm,
	input  wire                        comp_inverse,
	input  wire [pwm_pkg::CAR_W-1:0]   carrier_period,
	input  wire [pwm_pkg::CAR_W-1:0]   block_duty,
	input  wire [pwm_pkg::AMP_W-1:0]   amplitude,
	input  wire [pwm_pkg::SPD_W-1:0]   speed_step,
	output logic                       gate_u_hi,
	output logic                       gate_u_lo,
	output logic                       gate_v_hi,
	output logic                       gate_v_lo,
	output logic                       gate_w_hi,
	output logic                       gate_w_lo,
	output logic [2:0]                 sector,
	output logic                       carrier_down
);
	import pwm_pkg::*;

	typedef struct packed {
		logic [PH_W-1:0]            phase;
		logic [CAR_W-1:0]           carrier;
		logic                       dir_down;
		logic [NPH-1:0]             hi;
		logic [NPH-1:0]             lo;
		logic [NPH-1:0][DT_W-1:0]   dcnt;
		logic [2:0]                 sec_u;
	} state_type;

	state_type r;
	state_type n;

	logic        [ANG_W-1:0]   ang   [NPH];
	logic        [2:0]         sec   [NPH];
	logic signed [SIN_W-1:0]   vref  [NPH];
	logic signed [SIN_W-1:0]   vmod  [NPH];
	logic signed [22:0]        sprod [NPH];
	logic signed [26:0]        cprod [NPH];
	logic signed [15:0]        refc  [NPH];
	logic signed [SIN_W-1:0]   vmax;
	logic signed [SIN_W-1:0]   vmin;
	logic signed [SIN_W-1:0]   voff;
	logic        [NPH-1:0]     pwm;
	logic        [NPH-1:0]     clamp_hi;
	logic        [NPH-1:0]     clamp_lo;
	logic        [NPH-1:0]     pat_h;
	logic        [NPH-1:0]     pat_l;
	logic        [NPH-1:0]     want_hi;
	logic        [NPH-1:0]     want_lo;
	logic                      chop;

	function automatic logic signed [SIN_W-1:0] sine_of(
		input logic [ANG_W-1:0] a);
		logic [3:0]  idx;
		logic [10:0] mag;
		idx = a[14] ? ~a[13:10] : a[13:10];
		mag = SINE_Q[idx];
		return a[15] ? -$signed({3'h0, mag}) : $signed({3'h0, mag});
	endfunction : sine_of

	function automatic logic [2:0] sector_of(input logic [ANG_W-1:0] a);
		logic [18:0] p;
		p = {3'h0, a} * 19'(SECTORS);
		return p[18:16];
	endfunction : sector_of

	always_comb begin
		n = r;
		n.phase = r.phase + PH_W'(speed_step);
		// Carrier: triangle between zero and the period
		if (carrier_period == '0) begin
			n.carrier  = '0;
			n.dir_down = 1'b0;
		end else if (!r.dir_down) begin
			if (r.carrier >= carrier_period) begin
				n.dir_down = 1'b1;
				n.carrier  = r.carrier - 12'h001;
			end else begin
				n.carrier = r.carrier + 12'h001;
			end
		end else if (r.carrier == '0) begin
			n.dir_down = 1'b0;
			n.carrier  = 12'h001;
		end else begin
			n.carrier = r.carrier - 12'h001;
		end
		chop = block_duty > r.carrier;
		for (int i = 0; i < NPH; i++) begin
			ang[i]   = r.phase[PH_W-1 -: ANG_W] - LAG[i];
			sec[i]   = sector_of(ang[i]);
			sprod[i] = sine_of(ang[i]) * $signed({1'b0, amplitude});
			vref[i]  = sprod[i][21:8];
		end
		vmax = vref[0];
		vmin = vref[0];
		for (int i = 1; i < NPH; i++) begin
			if (vref[i] > vmax) begin
				vmax = vref[i];
			end
			if (vref[i] < vmin) begin
				vmin = vref[i];
			end
		end
		// Zero-sequence shift pins one phase to a rail
		case (mode)
			MODE_DPWM_BOTH: begin
				if (vmax + vmin >= 14'sh0000) begin
					voff = FULL - vmax;
				end else begin
					voff = -FULL - vmin;
				end
			end
			MODE_DPWM_LOW: voff = -FULL - vmin;
			default: voff = '0;
		endcase
		for (int i = 0; i < NPH; i++) begin
			vmod[i]     = vref[i] + voff;
			clamp_hi[i] = vmod[i] >= FULL;
			clamp_lo[i] = vmod[i] <= -FULL;
			cprod[i]    = vmod[i] * $signed({1'b0, carrier_period});
			refc[i]     = $signed({4'h0, carrier_period >> 1})
				+ $signed({cprod[i][26], cprod[i][26:12]});
			pwm[i]      = refc[i] > $signed({4'h0, r.carrier});
			if (mode == MODE_BLK180) begin
				pat_h[i] = sec[i] < SEC_HALF;
				pat_l[i] = !pat_h[i];
			end else begin
				pat_h[i] = sec[i] < SEC_H120_E;
				pat_l[i] = sec[i] >= SEC_L120_B && sec[i] < SEC_L120_E;
			end
			case (mode)
				MODE_BLK120: begin
					want_hi[i] = pat_h[i] & (low_side_pwm | chop);
					want_lo[i] = pat_l[i] & (!low_side_pwm | chop);
				end
				MODE_BLK180: begin
					want_hi[i] = pat_h[i] ? chop : comp_inverse & !chop;
					want_lo[i] = pat_h[i] ? comp_inverse & !chop : chop;
				end
				MODE_SINE3, MODE_DPWM_BOTH, MODE_DPWM_LOW: begin
					want_hi[i] = clamp_hi[i] | (!clamp_lo[i] & pwm[i]);
					want_lo[i] = !want_hi[i];
				end
				default: begin
					want_hi[i] = 1'b0;
					want_lo[i] = 1'b0;
				end
			endcase
			// Turn-off is immediate, turn-on waits out the dead count.
			// Re-enabling the same switch also waits: this trims short
			// chopped pulses but keeps the stage simple and safe.
			if ((r.hi[i] && !want_hi[i]) || (r.lo[i] && !want_lo[i])) begin
				n.hi[i]   = r.hi[i] & want_hi[i];
				n.lo[i]   = r.lo[i] & want_lo[i];
				n.dcnt[i] = DEAD_CYCLES;
			end else if (r.dcnt[i] != '0) begin
				n.dcnt[i] = r.dcnt[i] - 8'h01;
			end else begin
				n.hi[i] = want_hi[i] & !want_lo[i] & !r.lo[i];
				n.lo[i] = want_lo[i] & !want_hi[i] & !r.hi[i];
			end
		end
		n.sec_u = sec[0];
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign gate_u_hi    = r.hi[0];
	assign gate_u_lo    = r.lo[0];
	assign gate_v_hi    = r.hi[1];
	assign gate_v_lo    = r.lo[1];
	assign gate_w_hi    = r.hi[2];
	assign gate_w_lo    = r.lo[2];
	assign sector       = r.sec_u;
	assign carrier_down = r.dir_down;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_lo_quiet;
		!r.lo[0] [*8];
	endsequence

	sequence s_waited;
		$past(r.dcnt[0]) == '0 && !$past(r.hi[0]);
	endsequence

	// Mirror of the two sequences above for a low-to-high handover
	sequence s_hi_quiet;
		!r.hi[0] [*8];
	endsequence

	sequence s_waited_hi;
		$past(r.dcnt[0]) == '0 && !$past(r.lo[0]);
	endsequence

	chk_gate_interlock: assert property ((r.hi & r.lo) == '0)
		else $error("high and low gate on together");
	chk_dead_gap: assert property ($fell(r.hi[0]) |-> s_lo_quiet)
		else $error("low gate on inside dead interval");
	chk_dead_load: assert property (
		$fell(r.hi[0]) |-> r.dcnt[0] == DEAD_CYCLES)
		else $error("dead count not loaded at turn-off");
	chk_turn_on_wait: assert property ($rose(r.lo[0]) |-> s_waited)
		else $error("low gate turned on before dead count expired");
	chk_blk120_pattern: assert property (
		mode == MODE_BLK120 |-> $onehot(pat_h) && $onehot(pat_l)
		&& (pat_h & pat_l) == '0)
		else $error("120 pattern lacks one high, one low, one idle");
	chk_blk180_hold: assert property (
		mode == MODE_BLK180 && !comp_inverse
		|-> ((pat_h & want_lo) | (~pat_h & want_hi)) == '0)
		else $error("complement switch not held off");
	chk_blk180_inv: assert property (
		mode == MODE_BLK180 && comp_inverse |-> (want_hi ^ want_lo) == '1)
		else $error("complement is not the inverted chop");
	chk_sine_compl: assert property (
		mode == MODE_SINE3 |-> want_lo == ~want_hi && want_hi == pwm)
		else $error("sine mode gate pair not complementary");
	chk_two_clamp: assert property (
		(mode == MODE_DPWM_BOTH || mode == MODE_DPWM_LOW)
		|-> (clamp_hi | clamp_lo) != '0)
		else $error("no phase clamped in two-phase mode");
	chk_lower_clamp: assert property (
		mode == MODE_DPWM_LOW |-> clamp_lo != '0 && clamp_hi == '0)
		else $error("lower-arm variant did not clamp lowest phase low");
	chk_carrier_step: assert property (
		carrier_period != '0 && r.carrier <= carrier_period
		&& $stable(carrier_period) |=> r.carrier <= carrier_period
		&& (r.carrier == $past(r.carrier) + 12'h001
		|| r.carrier == $past(r.carrier) - 12'h001))
		else $error("carrier left range or skipped a count");
	chk_phase_step: assert property (
		1'b1 |=> r.phase == $past(r.phase) + PH_W'($past(speed_step)))
		else $error("reference phase did not advance by speed step");
	chk_dead_gap_hi: assert property ($fell(r.lo[0]) |-> s_hi_quiet)
		else $error("high gate on inside dead interval");
	chk_hi_on_wait: assert property ($rose(r.hi[0]) |-> s_waited_hi)
		else $error("high gate turned on before dead count expired");
	chk_blk120_hichop: assert property (
		mode == MODE_BLK120 && !low_side_pwm |-> want_lo == pat_l)
		else $error("low side chopped while high side selected");
	chk_blk120_lochop: assert property (
		mode == MODE_BLK120 && low_side_pwm |-> want_hi == pat_h)
		else $error("high side chopped while low side selected");
	chk_sine_free: assert property (
		mode == MODE_SINE3 |-> (clamp_hi | clamp_lo) == '0)
		else $error("phase clamped in three-phase mode");
	chk_both_arm_one: assert property (
		mode == MODE_DPWM_BOTH |-> $onehot({|clamp_hi, |clamp_lo}))
		else $error("both-arm variant clamps to both rails");
	chk_carrier_top: assert property (
		carrier_period != '0 && !r.dir_down
		&& r.carrier == carrier_period |=> r.dir_down)
		else $error("carrier did not turn at the period");
	chk_carrier_bottom: assert property (
		r.dir_down && r.carrier == '0 |=> !r.dir_down)
		else $error("carrier did not turn at zero");

	// Phase U is watched above, its load checked at high turn-off only; V and W get the load check at either turn-off
	for (genvar g = 1; g < NPH; g++) begin : g_dead_chk
		chk_dead_phase: assert property (
			$fell(r.hi[g]) || $fell(r.lo[g])
			|-> r.dcnt[g] == DEAD_CYCLES)
			else $error("dead count not loaded on phase turn-off");
	end
endmodule : three_phase_commutation_pwm

// file: bridge_model.sv
// Gate driver and bridge model that tallies gate events per phase
`timescale 1ns/1ps
module bridge_model (
	input  wire        core_clk,
	input  wire        clr,
	input  wire [2:0]  hi,
	input  wire [2:0]  lo,
	output logic [2:0] lvl,
	output int         hc [3],
	output int         lc [3],
	output int         hr [3],
	output int         lr [3],
	output int         tr [3],
	output int         mg [3],
	output int         g120,
	output int         anylo,
	output int         shoot
);
	int         cyc;
	int         gap [3];
	logic [2:0] hq;
	logic [2:0] lq;
	always @(posedge core_clk) begin
		hq <= hi;
		lq <= lo;
		if (clr) begin
			{cyc, g120, anylo, shoot} <= '0;
			for (int p = 0; p < 3; p++) begin
				{hc[p], lc[p], hr[p], lr[p], tr[p]} <= '0;
				mg[p] <= 1000000;
				// Large start so a gap cut by the window is never taken
				gap[p] <= 1000000;
			end
		end else begin
			cyc <= cyc + 1;
			g120 <= g120 + int'($countones(hi) == 1 && $countones(lo) == 1);
			anylo <= anylo + int'(|lo);
			shoot <= shoot + int'(|(hi & lo));
			for (int p = 0; p < 3; p++) begin
				hc[p] <= hc[p] + int'(hi[p]);
				lc[p] <= lc[p] + int'(lo[p]);
				hr[p] <= hr[p] + int'(hi[p] && !hq[p]);
				lr[p] <= lr[p] + int'(lo[p] && !lq[p]);
				if (hi[p] && !hq[p]) tr[p] <= cyc;
				if (!hi[p] && !lo[p]) gap[p] <= gap[p] + 1;
				else gap[p] <= 0;
				if ((hi[p] || lo[p]) && gap[p] > 0 && gap[p] < mg[p])
					mg[p] <= gap[p];
			end
		end
	end
	// An undriven phase node floats, so show it wandering
	always @(posedge core_clk)
		for (int p = 0; p < 3; p++)
			lvl[p] <= hi[p] ? 1'b1 : lo[p] ? 1'b0 : ~lvl[p];
endmodule : bridge_model

// file: tb_top.sv
// Self-checking bench for the three-phase gate generator
`timescale 1ns/1ps
module tb_top;
	import pwm_pkg::*;
	localparam int D = 8;
	localparam int N = 4096;
	logic             core_clk, rst_n, lsp, cinv, clr, dq;
	mode_type         mode;
	logic [CAR_W-1:0] per, bd;
	logic [AMP_W-1:0] amp;
	logic [SPD_W-1:0] spd;
	logic [2:0]       sq;
	int               schg;
	wire  [2:0]       hi, lo, sector, lvl;
	wire              cdown;
	int               hc [3], lc [3], hr [3], lr [3], tr [3], mg [3];
	int               g120, anylo, shoot, drise, ra, rs, dv;
	int               err_total, total_checks;
	int               pp [2] = '{20, 32};
	three_phase_commutation_pwm #(.DEAD_CYCLES(DT_W'(D))) dut (
		.core_clk(core_clk), .rst_n(rst_n), .mode(mode),
		.low_side_pwm(lsp), .comp_inverse(cinv), .carrier_period(per),
		.block_duty(bd), .amplitude(amp), .speed_step(spd),
		.gate_u_hi(hi[0]), .gate_u_lo(lo[0]), .gate_v_hi(hi[1]),
		.gate_v_lo(lo[1]), .gate_w_hi(hi[2]), .gate_w_lo(lo[2]),
		.sector(sector), .carrier_down(cdown));
	bridge_model bm (.core_clk(core_clk), .clr(clr), .hi(hi), .lo(lo),
		.lvl(lvl), .hc(hc), .lc(lc), .hr(hr), .lr(lr), .tr(tr), .mg(mg),
		.g120(g120), .anylo(anylo), .shoot(shoot));
	always @(posedge core_clk) begin
		dq <= cdown;
		drise <= clr ? 0 : drise + int'(cdown && !dq);
		sq <= sector;
		schg <= clr ? 0 : schg + int'(sector != sq);
	end
	task automatic chk(input int v, input int a, input int b);
		total_checks++;
		if (v < a || v > b) begin
			err_total++;
			$display("Error at %0t: got %0d, want %0d..%0d", $time, v, a, b);
		end
	endtask : chk
	task automatic give_verdict();
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : give_verdict
	// N clocks, one electrical cycle at speed step 16'h1000, are measured after the new mode settles
	task automatic run(input mode_type m, input logic l, input logic c,
		input logic [CAR_W-1:0] b, input logic [AMP_W-1:0] a);
		@(negedge core_clk);
		{mode, lsp, cinv, bd, amp} = {m, l, c, b, a};
		repeat (200) @(negedge core_clk);
		clr = 1;
		@(negedge core_clk);
		clr = 0;
		repeat (N) @(negedge core_clk);
		chk(shoot, 0, 0);
	endtask : run
	initial begin
		core_clk = 0;
		forever #25 core_clk = ~core_clk;
	end
	initial begin
		repeat (80000) @(posedge core_clk);
		err_total++;
		give_verdict();
	end
	initial begin
		{rst_n, clr, lsp, cinv} = '0;
		{mode, per, bd, amp} = {MODE_OFF, 12'h020, 12'hfff, 8'h00};
		spd = 16'h1000;
		repeat (20) @(negedge core_clk);
		rst_n = 1;
		for (int k = 0; k < 2; k++) begin
			per = CAR_W'(pp[k]);
			run(MODE_OFF, 0, 0, 12'hfff, 8'h00);
			chk(drise, N / (2 * pp[k]) - 1, N / (2 * pp[k]) + 1);
			chk(hc[0] + hc[1] + hc[2] + lc[0] + lc[1] + lc[2], 0, 0);
		end
		run(MODE_BLK120, 0, 0, 12'hfff, 8'h00);
		chk(g120, N - 6, N);
		for (int p = 0; p < 3; p++) chk(hc[p], 1360, 1370);
		for (int p = 0; p < 3; p++) chk(lc[p], 1352, 1370);
		for (int k = 0; k < 2; k++) begin
			run(MODE_BLK120, k[0], 0, 12'h010, 8'h00);
			chk(k ? lr[0] : hr[0], 15, 25);
			chk(k ? hr[0] : lr[0], 0, 2);
		end
		run(MODE_BLK180, 0, 0, 12'hfff, 8'h00);
		for (int p = 0; p < 3; p++) chk(mg[p], D + 1, D + 1);
		for (int p = 0; p < 3; p++) chk(hc[p], 2033, 2045);
		dv = tr[1] - tr[0];
		chk(dv < 0 ? dv + N : dv, 1359, 1371);
		dv = tr[2] - tr[0];
		chk(dv < 0 ? dv + N : dv, 2725, 2737);
		chk(schg, 6, 6);
		spd = 16'h2000;
		run(MODE_BLK180, 0, 0, 12'hfff, 8'h00);
		for (int p = 0; p < 3; p++) chk(hr[p], 2, 2);
		spd = 16'h1000;
		run(MODE_BLK180, 0, 0, 12'h010, 8'h00);
		ra = hr[0] + hr[1] + hr[2] + lr[0] + lr[1] + lr[2];
		run(MODE_BLK180, 0, 1, 12'h010, 8'h00);
		rs = hr[0] + hr[1] + hr[2] + lr[0] + lr[1] + lr[2];
		chk(rs * 100 / ra, 190, 210);
		run(MODE_SINE3, 0, 0, 12'hfff, 8'h00);
		for (int p = 0; p < 3; p++) chk(hc[p], 1370, 1446);
		for (int p = 0; p < 3; p++) chk(lc[p], 1498, 1574);
		for (int p = 0; p < 3; p++) chk(hr[p], 62, 66);
		run(MODE_SINE3, 0, 0, 12'hfff, 8'h80);
		rs = hr[0] + hr[1] + hr[2] + lr[0] + lr[1] + lr[2];
		run(MODE_DPWM_BOTH, 0, 0, 12'hfff, 8'h80);
		ra = hr[0] + hr[1] + hr[2] + lr[0] + lr[1] + lr[2];
		chk(ra * 300 / rs, 170, 230);
		run(MODE_DPWM_LOW, 0, 0, 12'hfff, 8'h80);
		chk(anylo, N - 40, N);
		give_verdict();
	end
endmodule : tb_top
